// File: core/seq_ctl_pkg.sv
// package: constants and carriers for the sequencer loop, debug and flag block
package seq_ctl_pkg;

  // ****************************************
  // widths and limits
  // ****************************************
  localparam int LOOP_W = 10;
  localparam int ADDR_W = 10;
  localparam int STACK_DEPTH_W = 4;
  localparam logic [3:0] STACK_FULL_LEVEL = 4'hF;
  localparam logic [9:0] LOOP_ZERO = 10'h000;
  localparam logic [9:0] LOOP_ONE = 10'h001;
  localparam int NUM_COND = 21;
  localparam int COND_SEL_W = 5;
  localparam int MASK_W = 9;
  localparam int MASK_DEBUG_MODE_BIT = 8;
  localparam int HOST_KIND_BIT = 5;
  localparam int HOST_ADDR_W = 8;

  // ****************************************
  // condition select codes
  // ****************************************
  localparam logic [4:0] COND_USER0 = 5'h00; // user inputs occupy codes 0..7
  localparam logic [4:0] COND_CARRY = 5'h08;
  localparam logic [4:0] COND_ZERO = 5'h09;
  localparam logic [4:0] COND_OVFL = 5'h0A;
  localparam logic [4:0] COND_SIGN = 5'h0B;
  localparam logic [4:0] COND_FIFO_KIND = 5'h0C;
  localparam logic [4:0] COND_FIFO_AVAIL = 5'h0D;
  localparam logic [4:0] COND_FIFO_SPACE = 5'h0E;
  localparam logic [4:0] COND_FIFO_MISUSE = 5'h0F;
  localparam logic [4:0] COND_ADDR_ONES = 5'h10;
  localparam logic [4:0] COND_BLOCK_ZERO = 5'h11;
  localparam logic [4:0] COND_STACK_FULL = 5'h12;
  localparam logic [4:0] COND_IRQ_PEND = 5'h13;
  localparam logic [4:0] COND_OUT_TAKEN = 5'h14;

  // ****************************************
  // carriers
  // ****************************************
  typedef enum logic [1:0] {
    LOOP_NONE,
    LOOP_OPEN,
    LOOP_CLOSE,
    LOOP_LOAD
  } loop_op_t;

  typedef enum logic {
    SRC_PROGRAM,
    SRC_CPU
  } load_src_t;

  // one loop instruction as the decoder presents it
  typedef struct packed {
    loop_op_t op;
    load_src_t src;
    logic nested;
    logic popRestore;
    logic [9:0] constValue;
  } loop_cmd_t;

  typedef struct packed {
    logic load;
    load_src_t src;
    logic [9:0] constValue;
  } halt_cmd_t;

  // raw arithmetic result from the cpu
  typedef struct packed {
    logic valid;
    logic carry;
    logic zero;
    logic ovfl;
    logic sign;
  } alu_flags_t;

  // fifo status from the command/data fifo
  typedef struct packed {
    logic full;
    logic empty;
    logic headKind;
    logic readCmd;
    logic readData;
  } fifo_stat_t;

  typedef struct packed {
    logic carry;
    logic zero;
    logic ovfl;
    logic sign;
  } cpu_flags_t;

endpackage

// File: core/seq_loop_debug_flags.sv
// sequencer loop counter, breakpoint/single-step unit and condition flags
//
// Notes on behaviour
// (R1) 10-bit loop down counter, also branch register
// (R2) any load value 0 to 1023 accepted
// (R3) loop open loads constant or cpu value
// (R4) loop close: nonzero decrements and repeats
// (R5) nested open pushes count; exit restores it
// (R6) loop count usable as call/jump target
// (R7) 10-bit halt register from constant or cpu
// (R8) breakpoint mode: address match raises debug irq
// (R9) single-step mode: debug irq every instruction
// (R10) mask bit 8 picks breakpoint or step
// (R11) 21 conditions testable true or false
// (R12) cpu flags valid one following instruction
// (R13) zero, carry/borrow, overflow, sign flags
// (R14) fifo space flag high when not full
// (R15) fifo kind flag from host address bit 5
// (R16) misuse flag on wrong-kind fifo read
// (R17) stack full at 15; fault irq unless masked
// (R18) pending flag while masked irq waits
// (R19) out-taken clears on write, sets on host read
// (R20) word-available flag when fifo holds a word
// (R21) synchronous updates; reset clears flags, mode
`timescale 1ns/1ps

module seq_loop_debug_flags (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction stream
  input wire logic instrDone,
  input wire logic [seq_ctl_pkg::ADDR_W-1:0] progAddr,
  input wire seq_ctl_pkg::loop_cmd_t loopCmd,
  input wire seq_ctl_pkg::halt_cmd_t haltCmd,
  input wire logic [seq_ctl_pkg::LOOP_W-1:0] cpuValue,
  // stack
  input wire logic [seq_ctl_pkg::LOOP_W-1:0] stackTop,
  input wire logic [seq_ctl_pkg::STACK_DEPTH_W-1:0] stackDepth,
  // mask and interrupts
  input wire logic [seq_ctl_pkg::MASK_W-1:0] maskReg,
  input wire logic faultMasked,
  input wire logic maskedIrqWaiting,
  // cpu, fifo and host
  input wire seq_ctl_pkg::alu_flags_t aluFlags,
  input wire seq_ctl_pkg::fifo_stat_t fifoStat,
  input wire logic [seq_ctl_pkg::HOST_ADDR_W-1:0] hostAddr,
  input wire logic outRegWrite,
  input wire logic outRegHostRead,
  // user and counter conditions
  input wire logic [7:0] userTestInputs,
  input wire logic addrOnes,
  input wire logic blockZero,
  // condition test request
  input wire logic [seq_ctl_pkg::COND_SEL_W-1:0] condSel,
  input wire logic condInvert,
  // loop and branch results
  output logic [seq_ctl_pkg::LOOP_W-1:0] iterationCountReg,
  output logic [seq_ctl_pkg::LOOP_W-1:0] branchVector,
  output logic loopRepeat,
  output logic stackPush,
  output logic [seq_ctl_pkg::LOOP_W-1:0] stackPushData,
  // debug
  output logic [seq_ctl_pkg::ADDR_W-1:0] haltMatchReg,
  output logic debugIrq,
  output logic singleStepMode,
  // flags
  output logic condTrue,
  output seq_ctl_pkg::cpu_flags_t cpuFlags,
  output logic fifoSpaceFlag,
  output logic fifoWordAvailFlag,
  output logic fifoKindFlag,
  output logic fifoMisuseFlag,
  output logic stackFullFlag,
  output logic faultIrq,
  output logic maskedIrqPending,
  output logic outRegTakenFlag
);

  // ****************************************
  // loop counter
  // ****************************************
  logic [seq_ctl_pkg::LOOP_W-1:0] loadValue;
  logic countIsZero;
  logic cpuFlagsLive;
  logic [20:0] condVec;

  // source mux shared by loop-open and plain load
  assign loadValue = (loopCmd.src == seq_ctl_pkg::SRC_CPU) ?
                     cpuValue : loopCmd.constValue; // [R3]
  assign countIsZero = (iterationCountReg == seq_ctl_pkg::LOOP_ZERO); // [R4]

  // full 10-bit range loads, no clamp needed [R2]
  always_ff @(posedge clk) begin
    if (rst) begin
      iterationCountReg <= seq_ctl_pkg::LOOP_ZERO;
    end else begin
      case (loopCmd.op)
        seq_ctl_pkg::LOOP_OPEN: iterationCountReg <= loadValue; // [R1] [R3]
        seq_ctl_pkg::LOOP_LOAD: iterationCountReg <= loadValue; // [R1]
        seq_ctl_pkg::LOOP_CLOSE: begin
          if (!countIsZero) begin
            iterationCountReg <= iterationCountReg - seq_ctl_pkg::LOOP_ONE; // [R4]
          end else if (loopCmd.popRestore) begin
            iterationCountReg <= stackTop; // inner loop left: outer count back [R5]
          end
        end
        default: iterationCountReg <= iterationCountReg;
      endcase
    end
  end

  // repeat strobe and push request, one cycle each
  always_ff @(posedge clk) begin
    if (rst) begin
      loopRepeat <= 1'b0;
      stackPush <= 1'b0;
      stackPushData <= seq_ctl_pkg::LOOP_ZERO;
    end else begin
      loopRepeat <= (loopCmd.op == seq_ctl_pkg::LOOP_CLOSE) && !countIsZero; // [R4]
      stackPush <= (loopCmd.op == seq_ctl_pkg::LOOP_OPEN) && loopCmd.nested; // [R5]
      stackPushData <= iterationCountReg; // old count, pushed before overwrite [R5]
    end
  end

  // branch vector mirrors the counter for call/jump use
  always_ff @(posedge clk) begin
    if (rst) begin
      branchVector <= seq_ctl_pkg::LOOP_ZERO;
    end else begin
      branchVector <= iterationCountReg; // one cycle behind the counter [R6]
    end
  end

  // ****************************************
  // breakpoint and single step
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      haltMatchReg <= seq_ctl_pkg::LOOP_ZERO;
    end else if (haltCmd.load) begin
      haltMatchReg <= (haltCmd.src == seq_ctl_pkg::SRC_CPU) ?
                      cpuValue : haltCmd.constValue; // [R7]
    end
  end

  // mode mirrored from the mask so reset forces breakpoint mode
  always_ff @(posedge clk) begin
    if (rst) begin
      singleStepMode <= 1'b0; // [R21]
    end else begin
      singleStepMode <= maskReg[seq_ctl_pkg::MASK_DEBUG_MODE_BIT]; // [R10]
    end
  end

  // both modes drive the same debug interrupt pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      debugIrq <= 1'b0;
    end else if (maskReg[seq_ctl_pkg::MASK_DEBUG_MODE_BIT]) begin
      debugIrq <= instrDone; // [R9] [R10]
    end else begin
      debugIrq <= instrDone && (progAddr == haltMatchReg); // [R8] [R10]
    end
  end

  // ****************************************
  // cpu flags
  // ****************************************
  // latched on a result; live only for the next instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      cpuFlags <= '0;
      cpuFlagsLive <= 1'b0;
    end else if (aluFlags.valid) begin
      cpuFlags.carry <= aluFlags.carry; // carry or borrow [R13]
      cpuFlags.zero <= aluFlags.zero; // [R13]
      cpuFlags.ovfl <= aluFlags.ovfl; // [R13]
      cpuFlags.sign <= aluFlags.sign; // [R13]
      cpuFlagsLive <= 1'b1; // [R12]
    end else if (instrDone && cpuFlagsLive) begin
      cpuFlagsLive <= 1'b0; // expired after the following instruction [R12]
    end
  end

  // ****************************************
  // fifo, stack, interrupt and output flags
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      fifoSpaceFlag <= 1'b0;
      fifoWordAvailFlag <= 1'b0;
      fifoKindFlag <= 1'b0;
    end else begin
      fifoSpaceFlag <= !fifoStat.full; // [R14]
      fifoWordAvailFlag <= !fifoStat.empty; // [R20]
      fifoKindFlag <= hostAddr[seq_ctl_pkg::HOST_KIND_BIT]; // 1 command, 0 data [R15]
    end
  end

  // sticky until reset; no software clear exists for it
  always_ff @(posedge clk) begin
    if (rst) begin
      fifoMisuseFlag <= 1'b0;
    end else if ((fifoStat.readCmd && !fifoStat.headKind) ||
                 (fifoStat.readData && fifoStat.headKind)) begin
      fifoMisuseFlag <= 1'b1; // [R16]
    end
  end

  // stack level, fault and pending flags
  always_ff @(posedge clk) begin
    if (rst) begin
      stackFullFlag <= 1'b0;
      faultIrq <= 1'b0;
      maskedIrqPending <= 1'b0;
    end else begin
      stackFullFlag <= (stackDepth >= seq_ctl_pkg::STACK_FULL_LEVEL); // [R17]
      faultIrq <= (stackDepth >= seq_ctl_pkg::STACK_FULL_LEVEL) && !faultMasked; // [R17]
      maskedIrqPending <= maskedIrqWaiting; // follows the controller's clear [R18]
    end
  end

  // host read wins over a same-cycle write so no read is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      outRegTakenFlag <= 1'b0;
    end else if (outRegHostRead) begin
      outRegTakenFlag <= 1'b1; // [R19]
    end else if (outRegWrite) begin
      outRegTakenFlag <= 1'b0; // [R19]
    end
  end

  // ****************************************
  // condition test
  // ****************************************
  // stale cpu flags read as false
  assign condVec = {outRegTakenFlag, maskedIrqPending, stackFullFlag, blockZero,
                    addrOnes, fifoMisuseFlag, fifoSpaceFlag, fifoWordAvailFlag,
                    fifoKindFlag, cpuFlags.sign & cpuFlagsLive,
                    cpuFlags.ovfl & cpuFlagsLive, cpuFlags.zero & cpuFlagsLive,
                    cpuFlags.carry & cpuFlagsLive, userTestInputs}; // [R12]

  // out-of-range selects return the invert bit
  always_ff @(posedge clk) begin
    if (rst) begin
      condTrue <= 1'b0;
    end else if (condSel < 5'(seq_ctl_pkg::NUM_COND)) begin
      condTrue <= condVec[condSel] ^ condInvert; // [R11]
    end else begin
      condTrue <= condInvert;
    end
  end

endmodule

// File: bench/seq_flags_monitor.sv
// checker: port properties of the sequencer loop, debug and flag block
`timescale 1ns/1ps
module seq_flags_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire logic instrDone,
  input wire logic [8:0] maskReg,
  input wire seq_ctl_pkg::loop_cmd_t loopCmd,
  input wire logic [9:0] iterationCountReg,
  input wire logic loopRepeat,
  input wire logic [3:0] stackDepth,
  input wire logic stackFullFlag,
  input wire logic [7:0] hostAddr,
  input wire logic fifoKindFlag,
  input wire seq_ctl_pkg::fifo_stat_t fifoStat,
  input wire logic fifoSpaceFlag,
  input wire logic outRegWrite,
  input wire logic outRegHostRead,
  input wire logic outRegTakenFlag,
  input wire seq_ctl_pkg::alu_flags_t aluFlags,
  input wire seq_ctl_pkg::cpu_flags_t cpuFlags,
  input wire logic debugIrq
);
  // ********
  // properties
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a close on a live count steps down by one and repeats
  sequence s_live_close;
    loopCmd.op == seq_ctl_pkg::LOOP_CLOSE && iterationCountReg != 10'h000;
  endsequence
  sequence s_counted_down;
    loopRepeat && iterationCountReg == $past(iterationCountReg) - 10'h001;
  endsequence
  property p_close; s_live_close |=> s_counted_down; endproperty
  a_close: assert property (p_close) else $error("close did not count down");
  // an open from a constant loads that constant
  property p_open;
    loopCmd.op == seq_ctl_pkg::LOOP_OPEN && loopCmd.src == seq_ctl_pkg::SRC_PROGRAM
      |=> iterationCountReg == $past(loopCmd.constValue);
  endproperty
  a_open: assert property (p_open) else $error("open did not load constant");
  property p_kind; 1'b1 |=> fifoKindFlag == $past(hostAddr[5]); endproperty
  a_kind: assert property (p_kind) else $error("kind flag wrong");
  property p_space; 1'b1 |=> fifoSpaceFlag != $past(fifoStat.full); endproperty
  a_space: assert property (p_space) else $error("space flag wrong");
  // host read wins over a same-cycle write
  property p_taken; outRegHostRead |=> outRegTakenFlag; endproperty
  a_taken: assert property (p_taken) else $error("taken flag not set");
  property p_clear; outRegWrite && !outRegHostRead |=> !outRegTakenFlag; endproperty
  a_clear: assert property (p_clear) else $error("taken flag not cleared");
  property p_step; instrDone && maskReg[8] |=> debugIrq; endproperty
  a_step: assert property (p_step) else $error("no step interrupt");
  property p_irq_cause; debugIrq |-> $past(instrDone); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("stray debug irq");
  property p_full; stackDepth == 4'hF |=> stackFullFlag; endproperty
  a_full: assert property (p_full) else $error("stack full missed");
  property p_alu;
    aluFlags.valid |=> cpuFlags == $past({aluFlags.carry, aluFlags.zero, aluFlags.ovfl,
      aluFlags.sign});
  endproperty
  a_alu: assert property (p_alu) else $error("cpu flags not latched");
endmodule
bind seq_loop_debug_flags seq_flags_monitor mon (.*);

// File: bench/host_fifo_model.sv
// host and fifo model: fills the fifo, reads the output register after a lag
`timescale 1ns/1ps
module host_fifo_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // device actions
  input wire logic outRegWrite,
  input wire logic readCmd,
  input wire logic readData,
  // host side of the block
  output logic [7:0] hostAddr,
  output logic outRegHostRead,
  output seq_ctl_pkg::fifo_stat_t fifoStat
);
  // ********
  // host behaviour
  // ********
  logic [2:0] fill;
  logic [1:0] lag;
  logic armed, kind;
  // address wanders every cycle; the head kind moves only when a word leaves
  always_ff @(posedge clk) begin
    outRegHostRead <= 1'b0;
    hostAddr <= 8'($urandom);
    if (rst) begin
      fill <= 3'h0;
      lag <= 2'h0;
      armed <= 1'b0;
      kind <= 1'b0;
    end else begin
      if ((readCmd | readData) && fill != 3'h0) begin
        fill <= fill - 3'h1;
        kind <= 1'($urandom);
      end else if (fill != 3'h4 && $urandom % 2 == 1) begin
        fill <= fill + 3'h1;
      end
      if (outRegWrite) begin
        armed <= 1'b1;
        lag <= 2'($urandom);
      end else if (armed && lag == 2'h0) begin
        armed <= 1'b0;
        outRegHostRead <= 1'b1;
      end else begin
        lag <= lag - 2'h1;
      end
    end
  end
  // status seen by the block; read strobes pass straight through
  assign fifoStat = '{fill == 3'h4, fill == 3'h0, kind, readCmd, readData};
endmodule

// File: bench/seq_loop_debug_flags_bench.sv
// self-checking bench for the sequencer loop, debug and flag block
`timescale 1ns/1ps
module seq_loop_debug_flags_bench;
  // ********
  // signals and parts
  // ********
  logic clk, rst, instrDone, faultMasked, maskedIrqWaiting, outRegWrite, outRegHostRead;
  logic addrOnes, blockZero, condInvert, loopRepeat, stackPush, debugIrq, singleStepMode;
  logic condTrue, fifoSpaceFlag, fifoWordAvailFlag, fifoKindFlag, fifoMisuseFlag;
  logic stackFullFlag, faultIrq, maskedIrqPending, outRegTakenFlag, readCmd, readData;
  logic [9:0] progAddr, cpuValue, stackTop, iterationCountReg, branchVector, stackPushData;
  logic [9:0] haltMatchReg, v;
  logic [3:0] stackDepth;
  logic [8:0] maskReg;
  logic [7:0] hostAddr, userTestInputs;
  logic [4:0] condSel;
  seq_ctl_pkg::loop_cmd_t loopCmd;
  seq_ctl_pkg::halt_cmd_t haltCmd;
  seq_ctl_pkg::alu_flags_t aluFlags;
  seq_ctl_pkg::fifo_stat_t fifoStat;
  seq_ctl_pkg::cpu_flags_t cpuFlags;
  int errTotal, nCompared, cycles;
  seq_loop_debug_flags DUT (.*);
  host_fifo_model host (.clk(clk), .rst(rst), .outRegWrite(outRegWrite), .readCmd(readCmd),
    .readData(readData), .hostAddr(hostAddr), .outRegHostRead(outRegHostRead), .fifoStat(fifoStat));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, far above the under two hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errTotal++;
      closeOut();
    end
  end
  task automatic closeOut();
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // eleven bits so a strobe packed above a 10-bit count is compared too
  task automatic chk(logic [10:0] got, logic [10:0] exp);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // codes past the last condition fall back to the invert bit
  function automatic logic condExp(logic [4:0] s, logic k, logic [7:0] u);
    return (s < 5'h15) ? u[s[2:0]] ^ k : k;
  endfunction
  task automatic lop(seq_ctl_pkg::loop_op_t op, seq_ctl_pkg::load_src_t src, logic nest,
      logic pop, logic [9:0] val);
    @(posedge clk);
    loopCmd <= '{op, src, nest, pop, val};
    @(posedge clk);
    loopCmd <= '0;
    #1;
  endtask
  task automatic ins(logic [9:0] a, logic step);
    @(posedge clk);
    instrDone <= 1'b1;
    progAddr <= a;
    maskReg <= {step, 8'h00};
    @(posedge clk);
    instrDone <= 1'b0;
    #1;
  endtask
  initial begin
    int r;
    logic [7:0] u;
    logic [4:0] s;
    logic e, k;
    {instrDone, faultMasked, maskedIrqWaiting, outRegWrite, addrOnes, blockZero} = '0;
    {condInvert, readCmd, readData, progAddr, cpuValue, stackTop, stackDepth} = '0;
    {maskReg, userTestInputs, condSel, loopCmd, haltCmd, aluFlags} = '0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    void'($urandom(18));
    cpuValue <= 10'h3FF;
    stackTop <= 10'($urandom);
    lop(seq_ctl_pkg::LOOP_OPEN, seq_ctl_pkg::SRC_CPU, 1'b0, 1'b0, 10'h000);
    chk(iterationCountReg, 10'h3FF);
    lop(seq_ctl_pkg::LOOP_OPEN, seq_ctl_pkg::SRC_PROGRAM, 1'b1, 1'b0, 10'h005);
    chk({stackPush, iterationCountReg}, 11'h005 | 11'h400);
    chk(stackPushData, 10'h3FF);
    for (int i = 5; i > 0; i--) begin
      lop(seq_ctl_pkg::LOOP_CLOSE, seq_ctl_pkg::SRC_PROGRAM, 1'b0, 1'b0, 10'h000);
      chk({loopRepeat, iterationCountReg}, {1'b1, 10'(i - 1)});
    end
    lop(seq_ctl_pkg::LOOP_CLOSE, seq_ctl_pkg::SRC_PROGRAM, 1'b0, 1'b1, 10'h000);
    chk({loopRepeat, iterationCountReg}, {1'b0, stackTop});
    @(posedge clk);
    #1 chk(branchVector, stackTop);
    v = 10'($urandom);
    @(posedge clk);
    cpuValue <= v;
    haltCmd <= '{1'b1, seq_ctl_pkg::SRC_CPU, 10'h000};
    @(posedge clk);
    haltCmd <= '0;
    #1 chk(haltMatchReg, v);
    ins(v, 1'b0);
    chk(debugIrq, 1'b1);
    ins(~v, 1'b0);
    chk(debugIrq, 1'b0);
    ins(~v, 1'b1);
    chk({debugIrq, singleStepMode}, 2'h3);
    // random user conditions mixed with codes beyond the table
    repeat (40) begin
      r = $urandom % 16;
      s = 5'(r < 8 ? r : r + 13);
      u = 8'($urandom);
      k = 1'($urandom);
      @(posedge clk);
      {userTestInputs, condSel, condInvert} <= {u, s, k};
      {addrOnes, blockZero} <= 2'($urandom);
      @(posedge clk);
      #1 chk(condTrue, condExp(s, k, u));
    end
    v = 10'($urandom);
    @(posedge clk);
    aluFlags <= {1'b1, v[3:0]};
    @(posedge clk);
    aluFlags <= '0;
    #1 chk(cpuFlags, v[3:0]);
    // carry stays testable until the next instruction ends, then reads false
    @(posedge clk);
    condSel <= seq_ctl_pkg::COND_CARRY;
    condInvert <= 1'b0;
    @(posedge clk);
    #1 chk(condTrue, v[3]);
    ins(~v, 1'b1);
    @(posedge clk);
    #1 chk(condTrue, 1'b0);
    @(posedge clk);
    {stackDepth, maskedIrqWaiting} <= 5'h1F;
    @(posedge clk);
    #1 chk({stackFullFlag, faultIrq, maskedIrqPending}, 3'h7);
    @(posedge clk);
    {faultMasked, maskedIrqWaiting} <= 2'h2;
    @(posedge clk);
    #1 chk({stackFullFlag, faultIrq, maskedIrqPending}, 3'h4);
    repeat (20) begin
      @(posedge clk);
      {e, k} = {fifoStat.empty, hostAddr[5]};
      #1 chk({fifoWordAvailFlag, fifoKindFlag}, {~e, k});
    end
    // a read of the right kind first, then one of the wrong kind
    for (int w = 0; w < 2; w++) begin
      @(posedge clk);
      readCmd <= fifoStat.headKind ^ w[0];
      readData <= ~fifoStat.headKind ^ w[0];
      @(posedge clk);
      {readCmd, readData} <= 2'h0;
      #1 chk(fifoMisuseFlag, w[0]);
    end
    @(posedge clk);
    outRegWrite <= 1'b1;
    @(posedge clk);
    outRegWrite <= 1'b0;
    #1 chk(outRegTakenFlag, 1'b0);
    for (int i = 0; i < 8 && outRegTakenFlag !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(outRegTakenFlag, 1'b1);
    closeOut();
  end
endmodule
